// [hw/vlms_top.sv]
// output-voltage ceiling, margin targets and slew rate command registers with clamping
`timescale 1ns/1ps
`include "vlms_regs.svh"

module vlms_top #(
    parameter logic [15:0] LSB_MV16  = `VLMS_LSB_MV16,
    parameter int          US_CYCLES = `VLMS_US_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    output logic             cmd_ack,
    output logic             cmd_nack,
    output logic      [15:0] cmd_rdata,
    input  wire logic [15:0] nvm_ceiling,
    input  wire logic [15:0] nvm_margin_upper,
    input  wire logic [15:0] nvm_margin_lower,
    input  wire logic [10:0] nvm_slew_mantissa,
    input  wire logic [15:0] nvm_offset,
    input  wire logic [15:0] nominal_target,
    input  wire logic [15:0] output_voltage_floor,
    input  wire logic [15:0] dac_limit,
    input  wire logic [1:0]  margin_field,
    input  wire logic        conv_enable,
    input  wire logic        clear_faults,
    output logic      [15:0] reference_target,
    output logic             ramp_busy,
    output logic             limit_clamp_warning,
    output logic             status_byte_nota,
    output logic             status_word_vout,
    output logic             vout_minmax_warn,
    output logic             cml_invalid_data,
    output logic             alert_active
);
    logic [15:0] output_voltage_ceiling;
    logic [15:0] margin_upper_target;
    logic [15:0] margin_lower_target;
    logic [15:0] target_slew_rate;
    logic [15:0] target_offset;
    logic [17:0] sum_q;
    logic [15:0] ceil_q;
    logic [15:0] floor_q;
    logic        en_q;
    logic [`VLMS_FLAG_COUNT-1:0] flags;

    vlms_slew_if sl ();

    // register port decode
    wire hit_off  = cmd_code == `VLMS_CMD_OFFSET;
    wire hit_ceil = cmd_code == `VLMS_CMD_CEILING;
    wire hit_mh   = cmd_code == `VLMS_CMD_MARGIN_HI;
    wire hit_ml   = cmd_code == `VLMS_CMD_MARGIN_LO;
    wire hit_slew = cmd_code == `VLMS_CMD_SLEW;
    wire hit      = hit_off | hit_ceil | hit_mh | hit_ml | hit_slew;
    wire wr       = cmd_valid & cmd_write;

    // write validity per register
    wire vlms_pkg::vlms_sum_t mh_wsum = vlms_pkg::vlms_add_offset(cmd_wdata, target_offset);
    wire vlms_pkg::vlms_sum_t ml_wsum = vlms_pkg::vlms_add_offset(cmd_wdata, target_offset);
    wire vlms_pkg::vlms_sum_t off_w   = $signed({{2{cmd_wdata[15]}}, cmd_wdata});
    wire [31:0] slew_wk  = vlms_pkg::vlms_slew_k(cmd_wdata);
    wire        ok_mh    = vlms_pkg::vlms_in_range(mh_wsum, output_voltage_ceiling);
    wire        ok_ml    = vlms_pkg::vlms_in_range(ml_wsum, dac_limit);
    wire        ok_slew  = slew_wk >= `VLMS_SLEW_MIN_K && slew_wk <= `VLMS_SLEW_MAX_K;
    wire        ok_off   = off_w >= -`VLMS_OFFSET_MAX && off_w <= `VLMS_OFFSET_MAX;
    wire        wr_ok    = hit_mh ? ok_mh : hit_ml ? ok_ml : hit_slew ? ok_slew : hit_off ? ok_off : 1'b1;
    wire        wr_take  = wr & hit & wr_ok;

    assign cmd_ack  = cmd_valid & hit & (!cmd_write | wr_ok);
    assign cmd_nack = wr & hit & !wr_ok;

    // applied rate in 1/16 mV/us, rounded to nearest; readback keeps the written word
    wire [31:0] slew_k    = vlms_pkg::vlms_slew_k(target_slew_rate);
    wire [31:0] rate_rnd  = (slew_k + 32'h0000_0020) >> 6;
    wire [7:0]  rate_app  = (rate_rnd == 32'h0) ? `VLMS_RATE_MIN :
                            (rate_rnd > 32'h0000_00ff) ? `VLMS_RATE_MAX : rate_rnd[7:0];

    // target selection, offset first, limits last
    wire [15:0] base = (margin_field == `VLMS_MARGIN_HIGH) ? margin_upper_target :
                       (margin_field == `VLMS_MARGIN_LOW)  ? margin_lower_target :
                       nominal_target;
    wire vlms_pkg::vlms_sum_t req_sum = vlms_pkg::vlms_add_offset(base, target_offset);
    wire        dac_caps  = dac_limit < output_voltage_ceiling;
    wire [15:0] top       = dac_caps ? dac_limit : output_voltage_ceiling;
    wire        over_top  = req_sum > $signed({2'b00, top});
    wire        over_ceil = req_sum > $signed({2'b00, output_voltage_ceiling});
    wire        below_flr = req_sum < $signed({2'b00, output_voltage_floor});
    wire [15:0] pick      = below_flr ? output_voltage_floor : over_top ? top : req_sum[15:0];
    // a floor above the ceiling still loses to the ceiling
    wire [15:0] target_req = (pick > output_voltage_ceiling) ? output_voltage_ceiling : pick;
    wire        warn_cond  = (over_ceil & !dac_caps) | below_flr;
    wire        changed    = (req_sum != $signed(sum_q)) | (output_voltage_ceiling != ceil_q) |
                             (output_voltage_floor != floor_q) | !en_q;

    assign limit_clamp_warning = conv_enable & warn_cond & changed;

    assign sl.target_req = target_req;
    assign sl.rate16     = rate_app;
    assign sl.jump       = !conv_enable;
    assign reference_target = sl.vref;
    assign ramp_busy        = sl.busy;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            sum_q   <= 18'h00000;
            ceil_q  <= 16'h0000;
            floor_q <= 16'h0000;
            en_q    <= 1'b0;
        end else begin
            sum_q   <= req_sum;
            ceil_q  <= output_voltage_ceiling;
            floor_q <= output_voltage_floor;
            en_q    <= conv_enable;
        end
    end

    // nvm defaults are sampled while reset is held, which is safe as reset is synchronous
    always_ff @(posedge clock) begin
        if (!nrst) begin
            output_voltage_ceiling <= nvm_ceiling;
            margin_upper_target    <= nvm_margin_upper;
            margin_lower_target    <= nvm_margin_lower;
            target_slew_rate       <= {`VLMS_SLEW_EXP_RST, nvm_slew_mantissa};
            target_offset          <= nvm_offset;
        end else if (wr_take) begin
            if (hit_ceil) output_voltage_ceiling <= cmd_wdata;
            if (hit_mh) margin_upper_target <= cmd_wdata;
            if (hit_ml) margin_lower_target <= cmd_wdata;
            if (hit_slew) target_slew_rate <= cmd_wdata;
            if (hit_off) target_offset <= cmd_wdata;
        end
    end

    wire [15:0] rd_sel = hit_ceil ? output_voltage_ceiling : hit_mh ? margin_upper_target :
                         hit_ml ? margin_lower_target : hit_slew ? target_slew_rate :
                         hit_off ? target_offset : 16'h0000;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cmd_rdata <= 16'h0000;
        end else if (cmd_valid && !cmd_write) begin
            cmd_rdata <= rd_sel;
        end
    end

    wire [`VLMS_FLAG_COUNT-1:0] flag_set = {cmd_nack, limit_clamp_warning, limit_clamp_warning,
                                            limit_clamp_warning};

    vlms_flags #(.N(`VLMS_FLAG_COUNT)) u_flags (
        .clock (clock),
        .nrst  (nrst),
        .set   (flag_set),
        .clr   (clear_faults),
        .flags (flags)
    );

    assign status_byte_nota = flags[`VLMS_FLAG_NOTA];
    assign status_word_vout = flags[`VLMS_FLAG_VOUT];
    assign vout_minmax_warn = flags[`VLMS_FLAG_MINMAX];
    assign cml_invalid_data = flags[`VLMS_FLAG_CML];
    assign alert_active     = |flags;

    vlms_slew #(.LSB_MV16(LSB_MV16), .US_CYCLES(US_CYCLES)) u_slew (
        .clock (clock),
        .nrst  (nrst),
        .sl    (sl.ramp)
    );

    // checks
    wire vlms_pkg::vlms_sum_t mh_sum = vlms_pkg::vlms_add_offset(margin_upper_target, target_offset);
    wire vlms_pkg::vlms_sum_t ml_sum = vlms_pkg::vlms_add_offset(margin_lower_target, target_offset);

    sequence s_refused;
        cmd_nack ##1 cml_invalid_data && alert_active;
    endsequence

    sequence s_flags_up;
        ##1 status_byte_nota && status_word_vout && vout_minmax_warn && alert_active;
    endsequence

    property p_ceiling_cap;
        @(posedge clock) disable iff (!nrst) 1'b1 |-> target_req <= output_voltage_ceiling;
    endproperty
    a_ceiling_cap: assert property (p_ceiling_cap) else $error("target above ceiling");

    property p_over_warn;
        @(posedge clock) disable iff (!nrst)
            (conv_enable && over_ceil && !dac_caps && (!en_q || output_voltage_ceiling != ceil_q))
            |-> limit_clamp_warning && target_req == top;
    endproperty
    a_over_warn: assert property (p_over_warn) else $error("over-ceiling target not clamped and flagged");

    property p_dac_quiet;
        @(posedge clock) disable iff (!nrst)
            (over_ceil && dac_caps && !below_flr) |-> !limit_clamp_warning && target_req == dac_limit;
    endproperty
    a_dac_quiet: assert property (p_dac_quiet) else $error("warning raised under reference range limit");

    property p_warn_status;
        @(posedge clock) disable iff (!nrst) limit_clamp_warning |-> s_flags_up;
    endproperty
    a_warn_status: assert property (p_warn_status) else $error("warning did not set status and alert");

    property p_ceiling_lowered;
        @(posedge clock) disable iff (!nrst)
            (wr && hit_ceil && conv_enable && $signed({2'b00, cmd_wdata}) < req_sum && cmd_wdata <= dac_limit
             && $signed({2'b00, cmd_wdata}) >= $signed({2'b00, output_voltage_floor}))
            |=> (!conv_enable || !over_ceil || limit_clamp_warning);
    endproperty
    a_ceiling_lowered: assert property (p_ceiling_lowered) else $error("lowered ceiling not flagged");

    property p_margin_high;
        @(posedge clock) disable iff (!nrst)
            (margin_field == `VLMS_MARGIN_HIGH && mh_sum >= $signed({2'b00, output_voltage_floor})
             && mh_sum <= $signed({2'b00, top})) |-> target_req == mh_sum[15:0];
    endproperty
    a_margin_high: assert property (p_margin_high) else $error("margin high target wrong");

    property p_margin_low;
        @(posedge clock) disable iff (!nrst)
            (margin_field == `VLMS_MARGIN_LOW && ml_sum >= $signed({2'b00, output_voltage_floor})
             && ml_sum <= $signed({2'b00, top})) |-> target_req == ml_sum[15:0];
    endproperty
    a_margin_low: assert property (p_margin_low) else $error("margin low target wrong");

    property p_mh_refused;
        @(posedge clock) disable iff (!nrst)
            (wr && hit_mh && !vlms_pkg::vlms_in_range(mh_wsum, output_voltage_ceiling))
            |-> s_refused and (##1 margin_upper_target == $past(margin_upper_target));
    endproperty
    a_mh_refused: assert property (p_mh_refused) else $error("bad margin high write kept");

    property p_ml_refused;
        @(posedge clock) disable iff (!nrst)
            (wr && hit_ml && !vlms_pkg::vlms_in_range(ml_wsum, dac_limit)) |-> s_refused;
    endproperty
    a_ml_refused: assert property (p_ml_refused) else $error("bad margin low write not refused");

    property p_off_jump;
        @(posedge clock) disable iff (!nrst) !conv_enable |=> reference_target == $past(target_req);
    endproperty
    a_off_jump: assert property (p_off_jump) else $error("reference did not follow while disabled");

    property p_slew_readback;
        @(posedge clock) disable iff (!nrst)
            (wr && hit_slew && cmd_ack) |=> target_slew_rate == $past(cmd_wdata);
    endproperty
    a_slew_readback: assert property (p_slew_readback) else $error("slew word not stored as written");

    property p_slew_refused;
        @(posedge clock) disable iff (!nrst)
            (wr && hit_slew && (slew_wk < `VLMS_SLEW_MIN_K || slew_wk > `VLMS_SLEW_MAX_K)) |-> s_refused;
    endproperty
    a_slew_refused: assert property (p_slew_refused) else $error("bad slew write not refused");

    property p_floor_clamp;
        @(posedge clock) disable iff (!nrst)
            (conv_enable && below_flr && (!en_q || output_voltage_floor != floor_q)
             && output_voltage_floor <= output_voltage_ceiling)
            |-> limit_clamp_warning && target_req == output_voltage_floor;
    endproperty
    a_floor_clamp: assert property (p_floor_clamp) else $error("under-floor target not clamped");

    property p_off_refused;
        @(posedge clock) disable iff (!nrst)
            (wr && hit_off && (off_w > `VLMS_OFFSET_MAX || off_w < -`VLMS_OFFSET_MAX))
            |-> s_refused and (##1 target_offset == $past(target_offset));
    endproperty
    a_off_refused: assert property (p_off_refused) else $error("bad offset write kept");
endmodule

// [hw/vlms_regs.svh]
// command codes, field positions, reset values and timing counts of the output-voltage limit block
`ifndef VLMS_REGS_SVH
`define VLMS_REGS_SVH

`define VLMS_CMD_OFFSET      8'h22
`define VLMS_CMD_CEILING     8'h24
`define VLMS_CMD_MARGIN_HI   8'h25
`define VLMS_CMD_MARGIN_LO   8'h26
`define VLMS_CMD_SLEW        8'h27

`define VLMS_MARGIN_LOW      2'h1
`define VLMS_MARGIN_HIGH     2'h2

`define VLMS_SLEW_EXP_MSB    15
`define VLMS_SLEW_EXP_LSB    11
`define VLMS_SLEW_MAN_MSB    10
`define VLMS_SLEW_EXP_RST    5'h1c

// slew limits in 1/1024 mV/us: 0.067 rounded up, 15.933 rounded down
`define VLMS_SLEW_MIN_K      32'h0000_0045
`define VLMS_SLEW_MAX_K      32'h0000_3fbb
`define VLMS_SLEW_K_SHIFT    5'h0a
`define VLMS_SLEW_EXP_LOW    5'h16
`define VLMS_SLEW_EXP_HIGH   5'h04
`define VLMS_RATE_MIN        8'h01
`define VLMS_RATE_MAX        8'hff

`define VLMS_OFFSET_MAX      18'sh0007f

`define VLMS_FLAG_NOTA       0
`define VLMS_FLAG_VOUT       1
`define VLMS_FLAG_MINMAX     2
`define VLMS_FLAG_CML        3
`define VLMS_FLAG_COUNT      4

`define VLMS_US_NS           1000
`define VLMS_CLK_NS          5
`define VLMS_US_CYCLES       (`VLMS_US_NS / `VLMS_CLK_NS)
`define VLMS_LSB_MV16        16'h001f

`endif

// [hw/vlms_pkg.sv]
// types and shared arithmetic of the output-voltage limit block
`include "vlms_regs.svh"

package vlms_pkg;

    typedef logic [15:0]        vlms_word_t;
    typedef logic signed [17:0] vlms_sum_t;

    typedef enum logic [1:0] {
        SL_IDLE = 2'b00,
        SL_UP   = 2'b01,
        SL_DOWN = 2'b11
    } vlms_slew_e;

    // base plus signed offset, wide enough to see both overflow and underflow
    function automatic vlms_sum_t vlms_add_offset(input vlms_word_t base, input vlms_word_t off);
        return $signed({2'b00, base}) + $signed({{2{off[15]}}, off});
    endfunction

    function automatic logic vlms_in_range(input vlms_sum_t v, input vlms_word_t hi);
        return (v >= 18'sh00000) && (v <= $signed({2'b00, hi}));
    endfunction

    // linear-11 slew word scaled to 1/1024 mV/us; unusable exponents and negatives give zero
    function automatic logic [31:0] vlms_slew_k(input vlms_word_t w);
        logic signed [4:0]  e;
        logic [10:0]        m;
        logic [31:0]        r;
        e = w[`VLMS_SLEW_EXP_MSB:`VLMS_SLEW_EXP_LSB];
        m = w[`VLMS_SLEW_MAN_MSB:0];
        r = 32'h0000_0000;
        if (!m[10] && e >= $signed(`VLMS_SLEW_EXP_LOW) && e <= $signed(`VLMS_SLEW_EXP_HIGH)) begin
            r = {21'h000000, m} << 5'(e + $signed(`VLMS_SLEW_K_SHIFT));
        end
        return r;
    endfunction

endpackage

// [hw/vlms_slew_if.sv]
// carrier between target selection and the slew stepper
`timescale 1ns/1ps

interface vlms_slew_if;
    logic [15:0] target_req;
    logic [7:0]  rate16;
    logic        jump;
    logic [15:0] vref;
    logic        busy;

    modport ctrl (output target_req, output rate16, output jump, input vref, input busy);
    modport ramp (input target_req, input rate16, input jump, output vref, output busy);
endinterface

// [hw/vlms_flags.sv]
// sticky status flags, set wins over clear
`timescale 1ns/1ps

module vlms_flags #(
    parameter int N = 4
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [N-1:0] set,
    input  wire logic         clr,
    output logic      [N-1:0] flags
);
    always_ff @(posedge clock) begin
        if (!nrst) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~{N{clr}}) | set;
        end
    end
endmodule

// [hw/vlms_slew.sv]
// reference stepper: moves toward the requested target at the programmed rate
`timescale 1ns/1ps
`include "vlms_regs.svh"

module vlms_slew #(
    parameter logic [15:0] LSB_MV16  = `VLMS_LSB_MV16,
    parameter int          US_CYCLES = `VLMS_US_CYCLES
) (
    input  wire logic clock,
    input  wire logic nrst,
    vlms_slew_if.ramp sl
);
    localparam int TW = (US_CYCLES > 1) ? $clog2(US_CYCLES) : 1;

    logic [TW-1:0]        tick_cnt;
    logic [15:0]          acc;
    vlms_pkg::vlms_slew_e state;
    vlms_pkg::vlms_slew_e next_state;

    wire        tick    = tick_cnt == TW'(US_CYCLES - 1);
    wire [15:0] acc_sum = acc + {8'h00, sl.rate16};
    // residue carries sub-lsb motion into the next microsecond so slow rates still move
    wire [15:0] steps   = acc_sum / LSB_MV16;
    wire [15:0] acc_rem = acc_sum % LSB_MV16;
    wire        go_up   = sl.target_req > sl.vref;
    wire        go_dn   = sl.target_req < sl.vref;
    wire [15:0] gap_up  = sl.target_req - sl.vref;
    wire [15:0] gap_dn  = sl.vref - sl.target_req;

    assign sl.busy = state != vlms_pkg::SL_IDLE;

    always_comb begin
        next_state = state;
        case (state)
            vlms_pkg::SL_IDLE: begin
                if (go_up) next_state = vlms_pkg::SL_UP;
                else if (go_dn) next_state = vlms_pkg::SL_DOWN;
            end
            vlms_pkg::SL_UP:   if (!go_up) next_state = vlms_pkg::SL_IDLE;
            vlms_pkg::SL_DOWN: if (!go_dn) next_state = vlms_pkg::SL_IDLE;
            default:           next_state = vlms_pkg::SL_IDLE;
        endcase
        if (sl.jump) next_state = vlms_pkg::SL_IDLE;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state   <= vlms_pkg::SL_IDLE;
            acc     <= 16'h0000;
            sl.vref <= 16'h0000;
        end else begin
            state <= next_state;
            if (sl.jump) begin
                sl.vref <= sl.target_req;
                acc     <= 16'h0000;
            end else if (tick && state == vlms_pkg::SL_UP && go_up) begin
                sl.vref <= (steps >= gap_up) ? sl.target_req : sl.vref + steps;
                acc     <= acc_rem;
            end else if (tick && state == vlms_pkg::SL_DOWN && go_dn) begin
                sl.vref <= (steps >= gap_dn) ? sl.target_req : sl.vref - steps;
                acc     <= acc_rem;
            end else if (state == vlms_pkg::SL_IDLE) begin
                acc <= 16'h0000;
            end
        end
    end
endmodule

// [tb/vlms_host.sv]
// host model for the command port: one word request per call
`timescale 1ns/1ps

module vlms_host (
    input  wire logic        clock,
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic      [7:0]  cmd_code,
    output logic      [15:0] cmd_wdata,
    input  wire logic        cmd_ack,
    input  wire logic        cmd_nack,
    input  wire logic [15:0] cmd_rdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    // ack and nack are taken at the accepting edge, the read word at the next falling edge, half a cycle later
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic ack, output logic nack, output logic [15:0] rd);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code  = c;
        cmd_wdata = d;
        @(posedge clock);
        ack  = cmd_ack;
        nack = cmd_nack;
        @(negedge clock);
        rd        = cmd_rdata;
        cmd_valid = 1'b0;
        // word left inverted so nothing leans on a stale value
        cmd_wdata = ~d;
    endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench for the output-voltage limit block
`timescale 1ns/1ps

module tb_top;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic        cmd_valid, cmd_write, cmd_ack, cmd_nack;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, vref;
    logic [15:0] nominal = 16'h0800;
    logic [15:0] nvm_off = 16'h0000;
    logic [15:0] floor_v = 16'h0100;
    logic [15:0] dac = 16'h2000;
    logic [1:0]  mfield = 2'h0;
    logic        en = 1'b0;
    logic        clr = 1'b0;
    logic        busy, warn, nota, vout, mm, cml, alert;
    logic        warn_seen = 1'b0;
    int          fail_count = 0;
    int          checks = 0;
    wire  [15:0] flag_w = {11'h000, warn_seen, nota, vout, mm, alert};

    always #2.5 clock = ~clock;
    // warning is a one-cycle pulse, so it is latched here
    // cleared with the flags; a warning in the same cycle wins
    always @(posedge clock) begin
        if (warn === 1'b1) begin
            warn_seen <= 1'b1;
        end else if (clr === 1'b1) begin
            warn_seen <= 1'b0;
        end
    end

    vlms_top #(.US_CYCLES(4)) i_vlms_top (
        .clock(clock), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .cmd_rdata(cmd_rdata),
        .nvm_ceiling(16'h1000), .nvm_margin_upper(16'h0c00), .nvm_margin_lower(16'h0400),
        .nvm_slew_mantissa(11'h0f0), .nvm_offset(nvm_off), .nominal_target(nominal),
        .output_voltage_floor(floor_v), .dac_limit(dac), .margin_field(mfield), .conv_enable(en),
        .clear_faults(clr), .reference_target(vref), .ramp_busy(busy), .limit_clamp_warning(warn),
        .status_byte_nota(nota), .status_word_vout(vout), .vout_minmax_warn(mm),
        .cml_invalid_data(cml), .alert_active(alert));

    vlms_host i_vlms_host (
        .clock(clock), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .cmd_rdata(cmd_rdata));

    task automatic close_out;
        $display("checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic ok);
        logic a, k;
        logic [15:0] r;
        i_vlms_host.xfer(1'b1, c, d, a, k, r);
        chk16("ack_nack", {14'h0, ok, !ok}, {14'h0, a, k});
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] e, input logic ok);
        logic a, k;
        logic [15:0] r;
        i_vlms_host.xfer(1'b0, c, 16'h0000, a, k, r);
        chk16("read_ack", {15'h0, ok}, {15'h0, a});
        chk16("read_word", e, r);
    endtask

    task automatic wait_ref(input logic [15:0] e);
        int n;
        n = 0;
        while (vref !== e && n < 4000) begin
            @(negedge clock);
            n++;
        end
        chk16("reference_target", e, vref);
        if (n == 4000) close_out();
    endtask

    task automatic pulse_clr;
        clr = 1'b1;
        @(negedge clock);
        clr = 1'b0;
        @(negedge clock);
    endtask

    initial begin
        repeat (12) @(negedge clock);
        nrst = 1'b1;
        rd(8'h24, 16'h1000, 1'b1);
        rd(8'h25, 16'h0c00, 1'b1);
        rd(8'h26, 16'h0400, 1'b1);
        rd(8'h27, 16'he0f0, 1'b1);
        rd(8'h30, 16'h0000, 1'b0);
        wait_ref(16'h0800);
        $display("test reset_values done");
        en = 1'b1;
        mfield = 2'h2;
        wait_ref(16'h0c00);
        mfield = 2'h1;
        wait_ref(16'h0400);
        wr(8'h22, 16'h0010, 1'b1);
        wait_ref(16'h0410);
        mfield = 2'h0;
        $display("test margins done");
        wr(8'h22, 16'h0080, 1'b0);
        wr(8'h22, 16'hff81, 1'b1);
        wr(8'h22, 16'h0010, 1'b1);
        wr(8'h25, 16'h0ff8, 1'b0);
        wr(8'h25, 16'h0ff0, 1'b1);
        wr(8'h26, 16'h3000, 1'b0);
        wr(8'h27, 16'he001, 1'b0);
        wr(8'h27, 16'he7ff, 1'b0);
        wr(8'h27, 16'he0fe, 1'b1);
        rd(8'h27, 16'he0fe, 1'b1);
        chk16("cml_alert", 16'h0003, {14'h0, cml, alert});
        pulse_clr();
        chk16("flags_cleared", 16'h0000, {flag_w[15:1], cml});
        $display("test refusals done");
        wr(8'h24, 16'h0600, 1'b1);
        wait_ref(16'h0600);
        chk16("clamp_flags", 16'h001f, flag_w);
        mfield = 2'h2;
        repeat (200) @(negedge clock);
        chk16("ceiling_holds", 16'h0600, vref);
        chk16("ramp_idle", 16'h0000, {15'h0000, busy});
        mfield = 2'h0;
        wr(8'h24, 16'h1000, 1'b1);
        wait_ref(16'h0810);
        pulse_clr();
        floor_v = 16'h0900;
        wait_ref(16'h0900);
        chk16("floor_flags", 16'h001f, flag_w);
        $display("test clamps done");
        floor_v = 16'h0100;
        dac = 16'h0700;
        wait_ref(16'h0700);
        pulse_clr();
        nominal = 16'h1100;
        repeat (20) @(negedge clock);
        chk16("dac_limited_quiet", 16'h0000, flag_w);
        $display("test dac_limit done");
        // second reset: nvm defaults reload, flags clear, reference restarts from zero
        nvm_off = 16'h0005;
        nrst = 1'b0;
        repeat (12) @(negedge clock);
        nrst = 1'b1;
        rd(8'h22, 16'h0005, 1'b1);
        rd(8'h24, 16'h1000, 1'b1);
        chk16("reset_flags", 16'h0000, flag_w);
        chk16("ramp_moving", 16'h0001, {15'h0000, busy});
        $display("test reset_reload done");
        close_out();
    end
endmodule
